// ===== ttc_regs.vh
// register map, field positions and codes of the triple timer/counter
// Function
// - three 16-bit timers, two with pins
// - internal timer prescales the others
// - counter readable and writable while running
// - maximum-count register sets terminal value
// - pin timers alternate between two limits
// - pin timers may use first limit only
// - terminal count zeroes counter, raises interrupt
// - each timer halts or continues at terminal
// - pin timers count processor clock or pin
// - pin timers restart on trigger event
`ifndef TTC_REGS_VH
`define TTC_REGS_VH

// ------------------------------------------------------------
// address layout: timer n at n*0x10, status at 0x30
// ------------------------------------------------------------
`define TTC_SEL_CNT   2'h0
`define TTC_SEL_MAXA  2'h1
`define TTC_SEL_MAXB  2'h2
`define TTC_SEL_CTRL  2'h3
`define TTC_IDX_NONE  2'h3
`define TTC_STAT_ADDR 8'h30

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define TTC_C_EN     0
`define TTC_C_INTEN  1
`define TTC_C_CONT   2
`define TTC_C_ALT    3
`define TTC_C_EXT    4
`define TTC_C_RETRIG 5
`define TTC_C_PRE    6
`define TTC_C_W      7
`define TTC_CTRL_RST 7'h00
`define TTC_T2_MASK  7'h07
`define TTC_MAX_RST  16'h0000
`define TTC_CNT_RST  16'h0000
`define TTC_STAT_RST 3'h0

// ------------------------------------------------------------
// bus answers
// ------------------------------------------------------------
`define TTC_RESP_OK  2'h0
`define TTC_RESP_ERR 2'h2
`define TTC_RD_ZERO  32'h0000_0000

`endif

// ===== ttc_sync.v
// two-flop synchroniser for the timer pins
`timescale 1ns/100ps
module ttc_sync (
  // clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  // pins in, synchronised level out
  input  wire [1:0] din,
  output reg  [1:0] dout
);

  reg [1:0] meta;

  always @(posedge aclk) begin
    if (!aresetn) begin
      meta <= 2'h0;
      dout <= 2'h0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule // ttc_sync

// ===== ttc_chan.v
// one 16-bit timer/counter channel
`timescale 1ns/100ps
`include "ttc_regs.vh"
module ttc_chan (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // mode
  input  wire        run,
  input  wire        alt,
  input  wire        use_ext,
  input  wire        use_pre,
  input  wire        retrig,
  // tick sources
  input  wire        in_rise,
  input  wire        pre_tc,
  // limits
  input  wire [15:0] max_a,
  input  wire [15:0] max_b,
  // software load
  input  wire        load,
  input  wire [15:0] load_val,
  // state
  output reg  [15:0] count,
  output reg         use_b,
  output wire        tc
);

  wire        tick;
  wire [15:0] limit;
  wire [15:0] inc;

  // internal clock, pin edge or prescaler terminal count
  assign tick  = run & (use_ext ? in_rise : (use_pre ? pre_tc : 1'b1));
  assign limit = use_b ? max_b : max_a;
  assign inc   = count + 16'h0001;
  assign tc    = tick & (inc == limit);

  always @(posedge aclk) begin
    if (!aresetn) begin
      count <= `TTC_CNT_RST;
      use_b <= 1'b0;
    end else begin
      if (load) begin
        count <= load_val;
      end else if (retrig & ~use_ext & in_rise) begin
        count <= `TTC_CNT_RST;
      end else if (tc) begin
        count <= `TTC_CNT_RST;
      end else if (tick) begin
        count <= inc;
      end
      if (!alt) begin
        use_b <= 1'b0;
      end else if (tc) begin
        use_b <= ~use_b;
      end
    end
  end

endmodule // ttc_chan

// ===== ttc_top.v
// triple timer/counter with AXI4-Lite register slave
`timescale 1ns/100ps
`include "ttc_regs.vh"
module ttc_top (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // write address channel
  input  wire [7:0]  awaddr,
  input  wire [2:0]  awprot,
  input  wire        awvalid,
  output wire        awready,
  // write data channel
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  // write response channel
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  // read address channel
  input  wire [7:0]  araddr,
  input  wire [2:0]  arprot,
  input  wire        arvalid,
  output wire        arready,
  // read data channel
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  // timer pins, clock or trigger of timers 0 and 1
  input  wire [1:0]  ext_in,
  // terminal-count requests to the interrupt controller
  output wire [2:0]  tc_irq
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0]  strb;
    begin
      merge16 = old;
      if (strb[0]) begin
        merge16[7:0] = data[7:0];
      end
      if (strb[1]) begin
        merge16[15:8] = data[15:8];
      end
    end
  endfunction

  // address falls below 0x40: the three timer slots and the status word
  function in_tmr;
    input [7:0] a;
    begin
      in_tmr = (a[7:6] == 2'h0);
    end
  endfunction

  // word-aligned and inside the map
  function addr_ok;
    input [7:0] a;
    begin
      addr_ok = (a[1:0] == 2'h0) &&
                ((a == `TTC_STAT_ADDR) ||
                 (in_tmr(a) && (a[5:4] != `TTC_IDX_NONE) &&
                  !((a[5:4] == 2'h2) && (a[3:2] == `TTC_SEL_MAXB))));
    end
  endfunction

  // one register of timer n
  function reg_hit;
    input [7:0] a;
    input [1:0] n;
    input [1:0] sel;
    begin
      reg_hit = in_tmr(a) && (a[5:4] == n) && (a[3:2] == sel);
    end
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  reg  [`TTC_C_W-1:0] ctrl [0:2];
  reg  [15:0]         max_a [0:2];
  reg  [15:0]         max_b [0:1];
  reg  [2:0]          done;
  reg  [1:0]          pin_prev;
  wire [1:0]          pin_lvl;
  wire [1:0]          pin_rise;
  wire [15:0]         cnt [0:2];
  wire [2:0]          use_b;
  wire [2:0]          tc;

  // write side of the bus
  reg         aw_full;
  reg         w_full;
  reg  [7:0]  aw_addr_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  wire        aw_fire;
  wire        w_fire;
  wire        wr_go;
  wire [7:0]  wa;
  wire [31:0] wd;
  wire [3:0]  ws;
  wire        wr_ok;
  wire [1:0]  w_idx;
  wire [1:0]  w_sel;
  wire [2:0]  load;
  reg  [31:0] rd_val;
  integer     i;

  // ------------------------------------------------------------
  // pin synchronisation and edge detection
  // ------------------------------------------------------------
  ttc_sync u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (ext_in),
    .dout    (pin_lvl)
  );

  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_prev <= 2'h0;
    end else begin
      pin_prev <= pin_lvl;
    end
  end

  assign pin_rise = pin_lvl & ~pin_prev;

  // ------------------------------------------------------------
  // three channels
  // ------------------------------------------------------------
  ttc_chan u_ch0 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (ctrl[0][`TTC_C_EN]),
    .alt      (ctrl[0][`TTC_C_ALT]),
    .use_ext  (ctrl[0][`TTC_C_EXT]),
    .use_pre  (ctrl[0][`TTC_C_PRE]),
    .retrig   (ctrl[0][`TTC_C_RETRIG]),
    .in_rise  (pin_rise[0]),
    .pre_tc   (tc[2]),
    .max_a    (max_a[0]),
    .max_b    (max_b[0]),
    .load     (load[0]),
    .load_val (merge16(cnt[0], wd, ws)),
    .count    (cnt[0]),
    .use_b    (use_b[0]),
    .tc       (tc[0])
  );

  ttc_chan u_ch1 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (ctrl[1][`TTC_C_EN]),
    .alt      (ctrl[1][`TTC_C_ALT]),
    .use_ext  (ctrl[1][`TTC_C_EXT]),
    .use_pre  (ctrl[1][`TTC_C_PRE]),
    .retrig   (ctrl[1][`TTC_C_RETRIG]),
    .in_rise  (pin_rise[1]),
    .pre_tc   (tc[2]),
    .max_a    (max_a[1]),
    .max_b    (max_b[1]),
    .load     (load[1]),
    .load_val (merge16(cnt[1], wd, ws)),
    .count    (cnt[1]),
    .use_b    (use_b[1]),
    .tc       (tc[1])
  );

  // internal timer: no pin, no second limit
  ttc_chan u_ch2 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (ctrl[2][`TTC_C_EN]),
    .alt      (1'b0),
    .use_ext  (1'b0),
    .use_pre  (1'b0),
    .retrig   (1'b0),
    .in_rise  (1'b0),
    .pre_tc   (1'b0),
    .max_a    (max_a[2]),
    .max_b    (max_a[2]),
    .load     (load[2]),
    .load_val (merge16(cnt[2], wd, ws)),
    .count    (cnt[2]),
    .use_b    (use_b[2]),
    .tc       (tc[2])
  );

  // one-cycle request on the terminal-count cycle
  assign tc_irq[0] = tc[0] & ctrl[0][`TTC_C_INTEN];
  assign tc_irq[1] = tc[1] & ctrl[1][`TTC_C_INTEN];
  assign tc_irq[2] = tc[2] & ctrl[2][`TTC_C_INTEN];

  // ------------------------------------------------------------
  // write channels: address and data taken in either order
  // ------------------------------------------------------------
  assign awready = ~aw_full & ~bvalid;
  assign wready  = ~w_full & ~bvalid;
  assign aw_fire = awvalid & awready;
  assign w_fire  = wvalid & wready;
  assign wr_go   = (aw_full | aw_fire) & (w_full | w_fire) & ~bvalid;
  assign wa      = aw_full ? aw_addr_q : awaddr;
  assign wd      = w_full ? w_data_q : wdata;
  assign ws      = w_full ? w_strb_q : wstrb;
  assign wr_ok   = wr_go & addr_ok(wa);
  assign w_idx   = wa[5:4];
  assign w_sel   = wa[3:2];

  // a counter write overrides any tick in the same cycle
  assign load[0] = wr_ok & reg_hit(wa, 2'h0, `TTC_SEL_CNT);
  assign load[1] = wr_ok & reg_hit(wa, 2'h1, `TTC_SEL_CNT);
  assign load[2] = wr_ok & reg_hit(wa, 2'h2, `TTC_SEL_CNT);

  // the response blocks new address and data until it is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full   <= 1'b0;
      w_full    <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= `TTC_RESP_OK;
    end else begin
      if (wr_go) begin
        aw_full <= 1'b0;
        w_full  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= addr_ok(wa) ? `TTC_RESP_OK : `TTC_RESP_ERR;
      end else begin
        if (aw_fire) begin
          aw_full   <= 1'b1;
          aw_addr_q <= awaddr;
        end
        if (w_fire) begin
          w_full   <= 1'b1;
          w_data_q <= wdata;
          w_strb_q <= wstrb;
        end
        if (bvalid & bready) begin
          bvalid <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // control, limits and sticky terminal-count flags
  // ------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < 3; i = i + 1) begin
        ctrl[i]  <= `TTC_CTRL_RST;
        max_a[i] <= `TTC_MAX_RST;
      end
      max_b[0] <= `TTC_MAX_RST;
      max_b[1] <= `TTC_MAX_RST;
      done     <= `TTC_STAT_RST;
    end else begin
      for (i = 0; i < 3; i = i + 1) begin
        // single-shot mode stops the timer at terminal count
        if (tc[i] & ~ctrl[i][`TTC_C_CONT]) begin
          ctrl[i][`TTC_C_EN] <= 1'b0;
        end
        if (wr_ok && in_tmr(wa) && (w_idx == i[1:0])) begin
          if ((w_sel == `TTC_SEL_CTRL) && ws[0]) begin
            if (i == 2) begin
              ctrl[i] <= wd[`TTC_C_W-1:0] & `TTC_T2_MASK;
            end else begin
              ctrl[i] <= wd[`TTC_C_W-1:0];
            end
          end
          if (w_sel == `TTC_SEL_MAXA) begin
            max_a[i] <= merge16(max_a[i], wd, ws);
          end
          if ((w_sel == `TTC_SEL_MAXB) && (i < 2)) begin
            max_b[i] <= merge16(max_b[i], wd, ws);
          end
        end
      end
      // write one to clear, a new terminal count wins
      if (wr_ok && (wa == `TTC_STAT_ADDR) && ws[0]) begin
        done <= (done & ~wd[2:0]) | tc;
      end else begin
        done <= done | tc;
      end
    end
  end

  // ------------------------------------------------------------
  // read channels
  // ------------------------------------------------------------
  // unmapped reads answer zero with an error code
  assign arready = ~rvalid;

  always @* begin
    rd_val = `TTC_RD_ZERO;
    if (araddr == `TTC_STAT_ADDR) begin
      rd_val[2:0] = done;
    end else begin
      case (araddr[5:4])
        2'h0, 2'h1, 2'h2: begin
          case (araddr[3:2])
            `TTC_SEL_CNT:  rd_val[15:0] = cnt[araddr[5:4]];
            `TTC_SEL_MAXA: rd_val[15:0] = max_a[araddr[5:4]];
            `TTC_SEL_MAXB: begin
              if (araddr[5:4] != 2'h2) begin
                rd_val[15:0] = max_b[araddr[4]];
              end
            end
            default: begin
              rd_val[`TTC_C_W-1:0] = ctrl[araddr[5:4]];
              rd_val[`TTC_C_W]     = use_b[araddr[5:4]];
            end
          endcase
        end
        default: rd_val = `TTC_RD_ZERO;
      endcase
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= `TTC_RD_ZERO;
      rresp  <= `TTC_RESP_OK;
    end else begin
      if (arvalid & arready) begin
        rvalid <= 1'b1;
        rdata  <= addr_ok(araddr) ? rd_val : `TTC_RD_ZERO;
        rresp  <= addr_ok(araddr) ? `TTC_RESP_OK : `TTC_RESP_ERR;
      end else if (rvalid & rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule // ttc_top

// ===== ttc_top_sva.sv
// port assertions of the timer block
`timescale 1ns/100ps
module ttc_top_sva (
  // clock and reset
  input wire        aclk,
  input wire        aresetn,
  // register bus
  input wire        awvalid,
  input wire        awready,
  input wire        wvalid,
  input wire        wready,
  input wire [1:0]  bresp,
  input wire        bvalid,
  input wire        bready,
  input wire        arvalid,
  input wire        arready,
  input wire [31:0] rdata,
  input wire [1:0]  rresp,
  input wire        rvalid,
  input wire        rready,
  // interrupt requests
  input wire [2:0]  tc_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_b_refuse: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response waits");
  chk_r_refuse: assert property (rvalid |-> !arready)
    else $error("read taken while data waits");
  chk_b_stand: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  chk_r_stand: assert property (rvalid && !rready |=>
    rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped early");
  chk_wr_answer: assert property (awvalid && awready && wvalid && wready |=> bvalid)
    else $error("write not answered next cycle");
  chk_rd_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered next cycle");
  chk_err_zero: assert property (rvalid && rresp == 2'h2 |-> rdata == 32'h0)
    else $error("error read carries data");
  chk_b_release: assert property (bvalid && bready |=> !bvalid)
    else $error("write response repeated");
  chk_irq_reset: assert property ($rose(aresetn) |-> tc_irq == 3'h0)
    else $error("interrupt out of reset");
endmodule // ttc_top_sva

// ===== ttc_pin_drv.sv
// outside world driving the timer pins
`timescale 1ns/100ps
module ttc_pin_drv (
  // clock
  input  wire        aclk,
  // pins toward the timers
  output logic [1:0] pins
);
  initial pins = 2'b00;
  // pulses long enough to pass the synchroniser
  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      @(posedge aclk);
      pins[idx] <= 1'b1;
      repeat (3) @(posedge aclk);
      pins[idx] <= 1'b0;
      repeat (3) @(posedge aclk);
    end
  endtask
endmodule // ttc_pin_drv

// ===== testbench.sv
// self-checking bench of the timer block
`timescale 1ns/100ps
module testbench;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [2:0]  awprot = 3'h0;
  logic [2:0]  arprot = 3'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic [31:0] rdata;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [2:0]  tc_irq;
  wire  [1:0]  ext_in;
  int          n_errors = 0;
  int          tests_run = 0;
  int          irq_cnt [3] = '{0, 0, 0};
  int          base;
  int          lag = 0;
  logic [31:0] rd;
  logic [1:0]  rs;

  ttc_top u_ttc_top (.aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .ext_in, .tc_irq);
  ttc_pin_drv u_pins (.aclk(aclk), .pins(ext_in));

  initial forever #5 aclk = ~aclk;
  always @(posedge aclk) for (int i = 0; i < 3; i++) irq_cnt[i] <= irq_cnt[i] + tc_irq[i];

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic hang();
    n_errors++;
    $display("ERROR wait expected answer seen none");
    give_verdict();
  endtask
  task automatic check(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (lag == 0);
    for (int n = 0; !tb; n++) begin
      if (n == 99) hang();
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      rs = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (!tb && n + 1 >= lag) bready <= 1'b1;
    end
    bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    logic ta, tr;
    tr = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (lag == 0);
    for (int n = 0; !tr; n++) begin
      if (n == 99) hang();
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      rd = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (!tr && n + 1 >= lag) rready <= 1'b1;
    end
    rready <= 1'b0;
  endtask
  task automatic expect_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    rd_reg(a);
    check("rdata", rd, e);
    check("rresp", {30'h0, rs}, {30'h0, r});
  endtask
  task automatic wait_irq(input int i);
    int n;
    n = 0;
    do begin
      if (n++ == 99) hang();
      @(negedge aclk);
    end while (tc_irq[i] !== 1'b1);
  endtask

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 8'h34; a += 4) expect_rd(8'(a), 32'h0, a == 8'h28 ? 2'h2 : 2'h0);
    $display("test reset_map done");
    lag = 2;
    wr(8'h00, 32'h1234);
    check("bresp", {30'h0, rs}, 32'h0);
    expect_rd(8'h00, 32'h1234, 2'h0);
    wstrb <= 4'h1;
    wr(8'h00, 32'habcd);
    wstrb <= 4'hf;
    expect_rd(8'h00, 32'h12cd, 2'h0);
    lag = 0;
    wr(8'h28, 32'hffff);
    check("bresp", {30'h0, rs}, 32'h2);
    $display("test access done");
    // one-shot of the internal timer, with and without interrupt
    wr(8'h24, 32'h5);
    for (int m = 0; m < 2; m++) begin
      base = irq_cnt[2];
      wr(8'h2c, m ? 32'h1 : 32'h3);
      repeat (20) @(negedge aclk);
      check("irq2", irq_cnt[2] - base, m ? 0 : 1);
      expect_rd(8'h20, 32'h0, 2'h0);
      expect_rd(8'h2c, m ? 32'h0 : 32'h2, 2'h0);
      expect_rd(8'h30, 32'h4, 2'h0);
      wr(8'h30, 32'h4);
      expect_rd(8'h30, 32'h0, 2'h0);
    end
    $display("test one_shot done");
    // single and alternating limits in continuous mode
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h3);
    wr(8'h08, 32'h2);
    for (int m = 0; m < 2; m++) begin
      wr(8'h0c, m ? 32'h0f : 32'h07);
      wait_irq(0);
      base = irq_cnt[0];
      repeat (45) @(negedge aclk);
      check("irq0", irq_cnt[0] - base, m ? 18 : 15);
      wr(8'h0c, 32'h0);
      wr(8'h00, 32'h0);
    end
    $display("test limits done");
    // pin clock, then retrigger
    wr(8'h14, 32'h100);
    wr(8'h1c, 32'h11);
    u_pins.pulse(1, 5);
    repeat (6) @(posedge aclk);
    expect_rd(8'h10, 32'h5, 2'h0);
    wr(8'h1c, 32'h21);
    repeat (100) @(posedge aclk);
    u_pins.pulse(1, 1);
    rd_reg(8'h10);
    check("retrig", 32'(rd < 32'h10), 32'h1);
    $display("test pins done");
    // timer 0 clocked by terminal counts of timer 2
    wr(8'h1c, 32'h0);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'hffff);
    wr(8'h24, 32'h4);
    wr(8'h2c, 32'h5);
    wr(8'h0c, 32'h41);
    repeat (40) @(posedge aclk);
    wr(8'h2c, 32'h0);
    rd_reg(8'h00);
    check("prescale", 32'(rd >= 32'h9 && rd <= 32'hc), 32'h1);
    $display("test prescale done");
    give_verdict();
  end
endmodule // testbench

bind ttc_top ttc_top_sva u_sva (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
  .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .tc_irq);
